// File: dv/swf_checker.sv
/*
 Port assertions for swf_top.
 Assumes: bound to swf_top from the bench top file.
*/
`timescale 1ns/1ns
module swf_checker
   import swf_pkg::*;
#(
   parameter int ADDR_W = 12
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [15:0] supply_mv,
   input wire logic undervolt_fault,
   input wire logic overvolt_fault,
   input wire logic irq
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // ==========================================================
   // Bus steps
   sequence s_wr_take;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence s_rd_take;
      s_axi_arvalid && s_axi_arready;
   endsequence
   a_write_answer: assert property (
      s_wr_take |=> s_axi_bvalid && !s_axi_awready)
      else $error("write not answered");
   a_bresp_holds: assert property (
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   a_busy_refused: assert property (
      s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while busy");
   a_read_answer: assert property (
      s_rd_take |=> s_axi_rvalid && !s_axi_arready)
      else $error("read not answered");
   a_rdata_holds: assert property (
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   // Outside the whole map region
   a_unmapped_err: assert property (
      s_rd_take ##0 (s_axi_araddr[ADDR_W-1 -: 2] != 2'h0) |=>
      s_axi_rresp == 2'h2) else $error("unmapped read not refused");
   // Latency of two or three edges from the reading
   a_uv_cause: assert property ($rose(undervolt_fault) |->
      $past(supply_mv, 2) < 16'h30D4 || $past(supply_mv, 3) < 16'h30D4)
      else $error("undervolt without low supply");
   a_ov_cause: assert property ($rose(overvolt_fault) |->
      $past(supply_mv, 2) > 16'h4E20 || $past(supply_mv, 3) > 16'h4E20)
      else $error("overvolt without high supply");
endmodule : swf_checker

// File: dv/swf_top_bench.sv
/*
 Self-checking bench for swf_top: map, window, recovery, interrupt.
 Assumes: swf_pkg, swf_top and swf_checker compiled before it.
*/
`timescale 1ns/1ns
`include "swf_regs.svh"
module swf_top_bench;
   typedef struct packed {
      logic [31:0] cfg;
      logic [15:0] mv;
      logic [1:0] flags;
   } swf_row_type;
   localparam logic [7:0] idx_cfg = `SWF_IDX_FAULT_TWO;
   localparam logic [7:0] idx_st = `SWF_IDX_STATUS;
   localparam logic [7:0] idx_msk = `SWF_IDX_MASK;
   localparam logic [7:0] idx_wait = `SWF_IDX_RETRY_WAIT;
   localparam logic [7:0] idx_clr = `SWF_IDX_CLEAR;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [11:0] awaddr = 12'h000;
   logic [11:0] araddr = 12'h000;
   logic [1:0] ahi = 2'b00;
   logic [31:0] wdata = 32'h0;
   logic [15:0] supply_mv = 16'h3A98;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, uvf, ovf, irq;
   logic [1:0] bresp, rresp, rsp;
   logic [31:0] rdata, rd_word;
   int err_count = 0;
   int checks_done = 0;
   // ==========================================================
   // Window rows: settings, reading, {under, over}
   swf_row_type rows [20] = '{
      '{32'h100, 16'h1193, 2'b10}, '{32'h100, 16'h1194, 2'b00},
      '{32'h200, 16'h1387, 2'b10}, '{32'h300, 16'h157B, 2'b10},
      '{32'h400, 16'h176F, 2'b10}, '{32'h500, 16'h1D4B, 2'b10},
      '{32'h600, 16'h270F, 2'b10}, '{32'h700, 16'h30D3, 2'b10},
      '{32'h700, 16'h30D4, 2'b00}, '{32'h000, 16'h0000, 2'b00},
      '{32'h010, 16'h4E21, 2'b01}, '{32'h010, 16'h4E20, 2'b00},
      '{32'h020, 16'h57E5, 2'b01}, '{32'h030, 16'h61A9, 2'b01},
      '{32'h040, 16'h6B6D, 2'b01}, '{32'h050, 16'h7531, 2'b01},
      '{32'h060, 16'h7EF5, 2'b01}, '{32'h070, 16'h88B9, 2'b01},
      '{32'h070, 16'h88B8, 2'b00}, '{32'h000, 16'hFFFF, 2'b00}};
   // Attempts allowed per retry code; code 0 runs 25 without lock
   int counts [8] = '{25, 2, 3, 5, 7, 10, 15, 20};

   swf_top #(.ADDR_W(12)) uut (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .supply_mv(supply_mv),
      .undervolt_fault(uvf), .overvolt_fault(ovf), .irq(irq));

   always #4 aclk = ~aclk;

   // ==========================================================
   // Checking and closing
   task cmp(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmp
   task report_and_stop;
      if (err_count == 0 && checks_done > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : report_and_stop
   // ==========================================================
   // Bus cycles; each starts after an edge so no double assignment
   task wr(input logic [7:0] idx, input logic [31:0] d);
      int n;
      @(posedge aclk);
      n = 0;
      awaddr <= {ahi, idx, 2'b00};
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (!bvalid && n < 100);
      rsp = bresp;
      bready <= 1'b0;
      if (!bvalid) begin
         err_count++;
         report_and_stop();
      end
   endtask : wr
   task rd(input logic [7:0] idx);
      int n;
      @(posedge aclk);
      n = 0;
      araddr <= {ahi, idx, 2'b00};
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (arvalid && arready) arvalid <= 1'b0;
      end while (!rvalid && n < 100);
      rd_word = rdata;
      rsp = rresp;
      rready <= 1'b0;
      if (!rvalid) begin
         err_count++;
         report_and_stop();
      end
   endtask : rd
   task wchk(input logic [7:0] idx, input logic [31:0] d,
      input logic [1:0] er);
      wr(idx, d);
      cmp({30'h0, rsp}, {30'h0, er});
   endtask : wchk
   task rchk(input logic [7:0] idx, input logic [31:0] e,
      input logic [1:0] er);
      rd(idx);
      cmp(rd_word, e);
      cmp({30'h0, rsp}, {30'h0, er});
   endtask : rchk
   // ==========================================================
   // Outputs {irq, under, over}
   task wait_out(input logic [2:0] e);
      int n;
      n = 0;
      do begin
         @(posedge aclk);
         n++;
      end while ({irq, uvf, ovf} !== e && n < 60);
      cmp({29'h0, irq, uvf, ovf}, {29'h0, e});
      if ({irq, uvf, ovf} !== e) report_and_stop();
   endtask : wait_out
   task hold_out(input logic [2:0] e);
      repeat (6) @(posedge aclk);
      cmp({29'h0, irq, uvf, ovf}, {29'h0, e});
   endtask : hold_out
   task retry_run(input logic [31:0] cfg, input logic [15:0] bad,
      input logic [2:0] e, input int n_ok, input bit lock);
      wchk(idx_clr, 32'h3, 2'h0);
      wchk(idx_cfg, cfg, 2'h0);
      repeat (n_ok) begin
         supply_mv <= bad;
         wait_out(e);
         supply_mv <= 16'h3A98;
         wait_out(3'b000);
      end
      // One attempt past the limit: fault outlives the retry wait
      if (lock) begin
         supply_mv <= bad;
         wait_out(e);
         supply_mv <= 16'h3A98;
         hold_out(e);
         hold_out(e);
      end
   endtask : retry_run
   // ==========================================================
   // Main sequence
   initial begin
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      cmp({29'h0, irq, uvf, ovf}, 32'h0);
      for (int i = 0; i < 6; i++) begin
         rchk(8'hA4 + 8'(2 * i), 32'h0, 2'h0);
         wchk(8'hA4 + 8'(2 * i), 32'hC35A_0F00 ^ i, 2'h0);
         rchk(8'hA4 + 8'(2 * i), 32'hC35A_0F00 ^ i, 2'h0);
      end
      rchk(idx_wait, 32'h0000_0400, 2'h0);
      wchk(8'hA5, 32'hFFFF_FFFF, 2'h2);
      rchk(8'hA5, 32'h0, 2'h2);
      // Upper address bits set: outside the whole map
      ahi = 2'b01;
      wchk(idx_cfg, 32'h7FF, 2'h2);
      rchk(idx_cfg, 32'h0, 2'h2);
      ahi = 2'b00;
      rchk(idx_cfg, 32'h0, 2'h0);
      foreach (rows[i]) begin
         wchk(idx_cfg, rows[i].cfg, 2'h0);
         supply_mv <= rows[i].mv;
         hold_out({1'b0, rows[i].flags});
         supply_mv <= 16'h3A98;
         hold_out({1'b0, rows[i].flags});
         wchk(idx_clr, 32'h3, 2'h0);
         hold_out(3'b000);
      end
      wchk(idx_wait, 32'h4, 2'h0);
      for (int c = 0; c < 8; c++) begin
         retry_run(32'h18 | c, 16'h4E21, 3'b001, counts[c], c != 0);
         if (c != 0) hold_out(3'b001);
      end
      retry_run(32'h181, 16'h0FA0, 3'b010, 2, 1'b1);
      hold_out(3'b010);
      rchk(`SWF_IDX_STATE, 32'h3A98_0005, 2'h0);
      wchk(idx_clr, 32'h3, 2'h0);
      wait_out(3'b000);
      wchk(idx_st, 32'hF, 2'h0);
      wchk(idx_msk, 32'h1, 2'h0);
      wchk(idx_cfg, 32'h100, 2'h0);
      supply_mv <= 16'h0FA0;
      wait_out(3'b110);
      supply_mv <= 16'h3A98;
      wchk(idx_clr, 32'h1, 2'h0);
      hold_out(3'b100);
      wchk(idx_msk, 32'h0, 2'h0);
      hold_out(3'b000);
      wchk(idx_msk, 32'h1, 2'h0);
      hold_out(3'b100);
      wchk(idx_st, 32'h1, 2'h0);
      hold_out(3'b000);
      rchk(idx_st, 32'h0, 2'h0);
      report_and_stop();
   end
endmodule : swf_top_bench

bind swf_top swf_checker #(.ADDR_W(ADDR_W)) chk (
   .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .supply_mv(supply_mv), .undervolt_fault(undervolt_fault),
   .overvolt_fault(overvolt_fault), .irq(irq));

// File: src/swf_pkg.sv
/*
 Types shared by the supply window fault block.
 Assumes: swf_regs.svh on the include path.
*/
package swf_pkg;
   `include "swf_regs.svh"

   // ==========================================================
   // Fault settings word
   typedef struct packed {
      logic [2:0] min_supply_run_limit;
      logic undervolt_recovery_sel;
      logic [2:0] max_supply_run_limit;
      logic overvolt_recovery_sel;
      logic [2:0] retry_attempt_limit;
   } swf_cfg_type;

   // ==========================================================
   // Per-fault view
   typedef struct packed {
      logic fault;
      logic locked;
   } swf_fault_type;

   typedef enum logic [1:0] {
      swf_idle, swf_active, swf_wait, swf_locked
   } swf_state_type;
endpackage : swf_pkg

// File: src/swf_recovery.sv
/*
 One fault recovery engine: latch or timed retry with an attempt cap.
 Assumes: condition and settings come from logic on the same clock.
*/
`timescale 1ns/1ns
`include "swf_regs.svh"
module swf_recovery
   import swf_pkg::*;
#(
   parameter int WAIT_W = 32
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic cond,
   input wire logic in_bounds,
   input wire logic auto_sel,
   input wire logic [4:0] limit,
   input wire logic [WAIT_W-1:0] wait_cycles,
   input wire logic sw_clear,
   output swf_fault_type view
);
   swf_state_type state;
   swf_state_type next_state;
   logic [5:0] attempts;
   logic [WAIT_W-1:0] wait_cnt;
   wire over_limit = (limit != 5'd0) && (attempts > {1'b0, limit});
   wire wait_done = wait_cnt >= wait_cycles;

   // ==========================================================
   // Next state
   always_comb begin
      next_state = state;
      case (state)
         swf_idle: if (cond) next_state = swf_active;
         swf_active: begin
            if (!auto_sel) begin
               if (sw_clear && in_bounds) next_state = swf_idle;
            end else if (over_limit) begin
               next_state = swf_locked;
            end else if (in_bounds) begin
               next_state = swf_wait;
            end
         end
         swf_wait: begin
            if (cond) next_state = swf_active;
            else if (wait_done) next_state = swf_idle;
         end
         default: if (sw_clear && in_bounds) next_state = swf_idle;
      endcase
   end

   // ==========================================================
   // State, attempt count, retry timer
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state <= swf_idle;
         attempts <= 6'd0;
         wait_cnt <= '0;
      end else begin
         state <= next_state;
         if (sw_clear) attempts <= 6'd0;
         else if (cond && state != swf_active && state != swf_locked &&
                  attempts != 6'h3F) attempts <= attempts + 6'd1;
         if (state == swf_wait) wait_cnt <= wait_cnt + 1'b1;
         else wait_cnt <= '0;
      end
   end

   assign view.fault = (state != swf_idle);
   assign view.locked = (state == swf_locked);
endmodule : swf_recovery

// File: src/swf_regs.svh
/*
 Register indices, field positions, reset values and lookup
 figures for the supply window fault block.
 Assumes: included by bare name from package and modules alike.
*/
`ifndef SWF_REGS_SVH
`define SWF_REGS_SVH

// ==========================================================
// Register indices (byte address is four times the index)
`define SWF_IDX_PIN_SETUP 8'hA4
`define SWF_IDX_DEV_ONE 8'hA6
`define SWF_IDX_DEV_TWO 8'hA8
`define SWF_IDX_PERI_ONE 8'hAA
`define SWF_IDX_GATE_ONE 8'hAC
`define SWF_IDX_GATE_TWO 8'hAE
`define SWF_IDX_FAULT_TWO 8'hA0
`define SWF_IDX_STATUS 8'hB0
`define SWF_IDX_MASK 8'hB1
`define SWF_IDX_RETRY_WAIT 8'hB2
`define SWF_IDX_STATE 8'hB3
`define SWF_IDX_CLEAR 8'hB4

// ==========================================================
// Field positions of fault_settings_two
`define SWF_MIN_HI 10
`define SWF_MIN_LO 8
`define SWF_UV_SEL 7
`define SWF_MAX_HI 6
`define SWF_MAX_LO 4
`define SWF_OV_SEL 3
`define SWF_RETRY_HI 2
`define SWF_RETRY_LO 0

// ==========================================================
// Status / mask bits, clear bits
`define SWF_ST_UV 0
`define SWF_ST_OV 1
`define SWF_ST_UV_LOCK 2
`define SWF_ST_OV_LOCK 3

// ==========================================================
// Reset values and bus answers
`define SWF_RST_WORD 32'h0000_0000
`define SWF_RST_FLAGS 4'h0
`define SWF_RST_RETRY_WAIT 32'h0000_0400
`define SWF_RESP_OKAY 2'h0
`define SWF_RESP_SLVERR 2'h2

// ==========================================================
// Thresholds in millivolts, retry counts
`define SWF_MIN_MV {16'd12500, 16'd10000, 16'd7500, 16'd6000, \
   16'd5500, 16'd5000, 16'd4500, 16'd0}
`define SWF_MAX_MV {16'd35000, 16'd32500, 16'd30000, 16'd27500, \
   16'd25000, 16'd22500, 16'd20000, 16'd0}
`define SWF_RETRY_TAB {5'd20, 5'd15, 5'd10, 5'd7, 5'd5, 5'd3, \
   5'd2, 5'd0}

`endif

// File: src/swf_top.sv
/*
 Supply window fault block: AXI4-Lite register file holding the six
 hardware configuration words and the fault settings, window
 comparison of the supply reading, recovery and interrupt.
 Assumes: supply_mv is a millivolt reading produced on aclk.
*/
// The AXI4-Lite interface to the registers was decided locally.
`timescale 1ns/1ns
`include "swf_regs.svh"
module swf_top
   import swf_pkg::*;
#(
   parameter int ADDR_W = 12
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [15:0] supply_mv,
   output logic undervolt_fault,
   output logic overvolt_fault,
   output logic irq
);
   // ==========================================================
   // Lookup functions
   function automatic logic [15:0] swf_min_mv(input logic [2:0] code);
      logic [127:0] tab;
      tab = `SWF_MIN_MV;
      return tab[code*16 +: 16];
   endfunction : swf_min_mv

   function automatic logic [15:0] swf_max_mv(input logic [2:0] code);
      logic [127:0] tab;
      tab = `SWF_MAX_MV;
      return tab[code*16 +: 16];
   endfunction : swf_max_mv

   function automatic logic [4:0] swf_tries(input logic [2:0] code);
      logic [39:0] tab;
      tab = `SWF_RETRY_TAB;
      return tab[code*5 +: 5];
   endfunction : swf_tries

   function automatic logic [31:0] swf_merge(input logic [31:0] old,
         input logic [31:0] wd, input logic [3:0] strb);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) res[i*8 +: 8] = wd[i*8 +: 8];
      end
      return res;
   endfunction : swf_merge

   // ==========================================================
   // Storage
   logic [31:0] hw_cfg [6];
   swf_cfg_type fault_settings_two;
   logic [3:0] irq_status;
   logic [3:0] irq_mask;
   logic [31:0] retry_wait_interval;

   // ==========================================================
   // Write channel capture: address and data in either order
   logic aw_have;
   logic w_have;
   logic [ADDR_W-1:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   wire aw_take = s_axi_awvalid && s_axi_awready;
   wire w_take = s_axi_wvalid && s_axi_wready;
   wire aw_now = aw_have || aw_take;
   wire w_now = w_have || w_take;
   wire do_write = aw_now && w_now && !s_axi_bvalid;
   wire [ADDR_W-1:0] wr_addr = aw_take ? s_axi_awaddr : aw_addr;
   wire [31:0] wr_data = w_take ? s_axi_wdata : w_data;
   wire [3:0] wr_strb = w_take ? s_axi_wstrb : w_strb;
   wire [7:0] wr_idx = wr_addr[9:2];
   wire next_aw_have = aw_now && !do_write;
   wire next_w_have = w_now && !do_write;
   wire next_bvalid = do_write || (s_axi_bvalid && !s_axi_bready);

   // ==========================================================
   // Write decode, and read hits for the six hardware words
   wire [5:0] wr_hw_hit;
   wire [5:0] rd_hw_hit;
   wire [7:0] rd_idx = s_axi_araddr[9:2];
   wire addr_hi_wr_ok = (wr_addr[ADDR_W-1:10] == '0);
   wire addr_hi_rd_ok = (s_axi_araddr[ADDR_W-1:10] == '0);

   genvar g;
   generate
      for (g = 0; g < 6; g++) begin : g_hw_hit
         localparam logic [7:0] IDX = 8'(`SWF_IDX_PIN_SETUP + 2 * g);
         assign wr_hw_hit[g] = addr_hi_wr_ok && (wr_idx == IDX);
         assign rd_hw_hit[g] = addr_hi_rd_ok && (rd_idx == IDX);
      end
   endgenerate

   wire wr_fault = addr_hi_wr_ok && (wr_idx == `SWF_IDX_FAULT_TWO);
   wire wr_status = addr_hi_wr_ok && (wr_idx == `SWF_IDX_STATUS);
   wire wr_mask = addr_hi_wr_ok && (wr_idx == `SWF_IDX_MASK);
   wire wr_wait = addr_hi_wr_ok && (wr_idx == `SWF_IDX_RETRY_WAIT);
   wire wr_state = addr_hi_wr_ok && (wr_idx == `SWF_IDX_STATE);
   wire wr_clear = addr_hi_wr_ok && (wr_idx == `SWF_IDX_CLEAR);
   wire wr_known = (|wr_hw_hit) || wr_fault || wr_status || wr_mask ||
      wr_wait || wr_state || wr_clear;
   wire [31:0] fault_word = {21'h0, fault_settings_two};
   wire [31:0] fault_merged = swf_merge(fault_word, wr_data, wr_strb);
   wire [31:0] wait_merged = swf_merge(retry_wait_interval, wr_data,
      wr_strb);
   wire [3:0] status_w1c = (do_write && wr_status && wr_strb[0]) ?
      wr_data[3:0] : 4'h0;
   wire [1:0] sw_clear = (do_write && wr_clear && wr_strb[0]) ?
      wr_data[1:0] : 2'h0;

   // ==========================================================
   // Window comparison
   wire [15:0] min_mv = swf_min_mv(fault_settings_two.min_supply_run_limit);
   wire [15:0] max_mv = swf_max_mv(fault_settings_two.max_supply_run_limit);
   wire uv_cond = (fault_settings_two.min_supply_run_limit != 3'd0) &&
      (supply_mv < min_mv);
   wire ov_cond = (fault_settings_two.max_supply_run_limit != 3'd0) &&
      (supply_mv > max_mv);
   wire in_bounds = !uv_cond && !ov_cond;
   wire [4:0] tries = swf_tries(fault_settings_two.retry_attempt_limit);

   // ==========================================================
   // Recovery engines
   swf_fault_type uv_view;
   swf_fault_type ov_view;

   swf_recovery #(
      .WAIT_W(32)
   ) u_uv_recovery (
      .aclk(aclk),
      .aresetn(aresetn),
      .cond(uv_cond),
      .in_bounds(in_bounds),
      .auto_sel(fault_settings_two.undervolt_recovery_sel),
      .limit(tries),
      .wait_cycles(retry_wait_interval),
      .sw_clear(sw_clear[`SWF_ST_UV]),
      .view(uv_view)
   );

   swf_recovery #(
      .WAIT_W(32)
   ) u_ov_recovery (
      .aclk(aclk),
      .aresetn(aresetn),
      .cond(ov_cond),
      .in_bounds(in_bounds),
      .auto_sel(fault_settings_two.overvolt_recovery_sel),
      .limit(tries),
      .wait_cycles(retry_wait_interval),
      .sw_clear(sw_clear[`SWF_ST_OV]),
      .view(ov_view)
   );

   // ==========================================================
   // Events: fault onset and lock-out, rising edges
   logic uv_prev;
   logic ov_prev;
   logic uv_lock_prev;
   logic ov_lock_prev;
   wire [3:0] events;
   assign events[`SWF_ST_UV] = uv_view.fault && !uv_prev;
   assign events[`SWF_ST_OV] = ov_view.fault && !ov_prev;
   assign events[`SWF_ST_UV_LOCK] = uv_view.locked && !uv_lock_prev;
   assign events[`SWF_ST_OV_LOCK] = ov_view.locked && !ov_lock_prev;
   // Set wins over a clear in the same cycle
   wire [3:0] next_status = (irq_status & ~status_w1c) | events;

   // ==========================================================
   // Read decode
   wire rd_fault = addr_hi_rd_ok && (rd_idx == `SWF_IDX_FAULT_TWO);
   wire rd_status = addr_hi_rd_ok && (rd_idx == `SWF_IDX_STATUS);
   wire rd_mask = addr_hi_rd_ok && (rd_idx == `SWF_IDX_MASK);
   wire rd_wait = addr_hi_rd_ok && (rd_idx == `SWF_IDX_RETRY_WAIT);
   wire rd_state = addr_hi_rd_ok && (rd_idx == `SWF_IDX_STATE);
   wire rd_clear = addr_hi_rd_ok && (rd_idx == `SWF_IDX_CLEAR);
   wire [31:0] state_word = {supply_mv, 12'h0, ov_view.locked,
      uv_view.locked, ov_view.fault, uv_view.fault};
   logic [31:0] rd_value;
   logic rd_known;

   always_comb begin
      rd_value = `SWF_RST_WORD;
      rd_known = 1'b1;
      if (rd_hw_hit[0]) begin
         rd_value = hw_cfg[0];
      end else if (rd_hw_hit[1]) begin
         rd_value = hw_cfg[1];
      end else if (rd_hw_hit[2]) begin
         rd_value = hw_cfg[2];
      end else if (rd_hw_hit[3]) begin
         rd_value = hw_cfg[3];
      end else if (rd_hw_hit[4]) begin
         rd_value = hw_cfg[4];
      end else if (rd_hw_hit[5]) begin
         rd_value = hw_cfg[5];
      end else if (rd_fault) begin
         rd_value = fault_word;
      end else if (rd_status) begin
         rd_value = {28'h0, irq_status};
      end else if (rd_mask) begin
         rd_value = {28'h0, irq_mask};
      end else if (rd_wait) begin
         rd_value = retry_wait_interval;
      end else if (rd_state) begin
         rd_value = state_word;
      end else if (rd_clear) begin
         rd_value = `SWF_RST_WORD;
      end else begin
         rd_known = 1'b0;
      end
   end

   wire ar_take = s_axi_arvalid && s_axi_arready;
   wire next_rvalid = ar_take || (s_axi_rvalid && !s_axi_rready);

   // ==========================================================
   // Bus handshake registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have <= 1'b0;
         w_have <= 1'b0;
         aw_addr <= '0;
         w_data <= `SWF_RST_WORD;
         w_strb <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `SWF_RESP_OKAY;
      end else begin
         aw_have <= next_aw_have;
         w_have <= next_w_have;
         if (aw_take) aw_addr <= s_axi_awaddr;
         if (w_take) w_data <= s_axi_wdata;
         if (w_take) w_strb <= s_axi_wstrb;
         s_axi_awready <= !next_aw_have && !next_bvalid;
         s_axi_wready <= !next_w_have && !next_bvalid;
         s_axi_bvalid <= next_bvalid;
         if (do_write) begin
            s_axi_bresp <= wr_known ? `SWF_RESP_OKAY : `SWF_RESP_SLVERR;
         end
      end
   end

   // Single read outstanding; arready drops while data waits
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= `SWF_RST_WORD;
         s_axi_rresp <= `SWF_RESP_OKAY;
      end else begin
         s_axi_arready <= !next_rvalid;
         s_axi_rvalid <= next_rvalid;
         if (ar_take) begin
            s_axi_rdata <= rd_value;
            s_axi_rresp <= rd_known ? `SWF_RESP_OKAY : `SWF_RESP_SLVERR;
         end
      end
   end

   // ==========================================================
   // Configuration registers
   generate
      for (g = 0; g < 6; g++) begin : g_hw_reg
         always_ff @(posedge aclk) begin
            if (!aresetn) hw_cfg[g] <= `SWF_RST_WORD;
            else if (do_write && wr_hw_hit[g]) begin
               hw_cfg[g] <= swf_merge(hw_cfg[g], wr_data, wr_strb);
            end
         end
      end
   endgenerate

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         fault_settings_two <= swf_cfg_type'(11'h000);
         retry_wait_interval <= `SWF_RST_RETRY_WAIT;
         irq_mask <= `SWF_RST_FLAGS;
      end else begin
         if (do_write && wr_fault) begin
            fault_settings_two <= swf_cfg_type'(fault_merged[10:0]);
         end
         if (do_write && wr_wait) retry_wait_interval <= wait_merged;
         if (do_write && wr_mask && wr_strb[0]) irq_mask <= wr_data[3:0];
      end
   end

   // ==========================================================
   // Status, interrupt and fault outputs
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_status <= `SWF_RST_FLAGS;
         uv_prev <= 1'b0;
         ov_prev <= 1'b0;
         uv_lock_prev <= 1'b0;
         ov_lock_prev <= 1'b0;
         irq <= 1'b0;
         undervolt_fault <= 1'b0;
         overvolt_fault <= 1'b0;
      end else begin
         irq_status <= next_status;
         uv_prev <= uv_view.fault;
         ov_prev <= ov_view.fault;
         uv_lock_prev <= uv_view.locked;
         ov_lock_prev <= ov_view.locked;
         irq <= |(next_status & irq_mask);
         undervolt_fault <= uv_view.fault;
         overvolt_fault <= ov_view.fault;
      end
   end
endmodule : swf_top
